// [rtl/umh_pkg.sv]
package umh_pkg;
  localparam int NUM_PORTS = 2;
  // Synchronised inputs of one port, in this order.
  localparam int SIG_CTS = 0;
  localparam int SIG_DSR = 1;
  localparam int SIG_RI = 2;
  localparam int SIG_DCD = 3;
  localparam int SIG_RXD = 4;
  localparam int SIGS_PER_PORT = 5;
  localparam int MODEM_SIGS = 4;
  // Extra synchronised pins after the port groups.
  localparam int SIG_DTR_STRAP = NUM_PORTS * SIGS_PER_PORT;
  localparam int SIG_RESUME = SIG_DTR_STRAP + 1;
  localparam int SYNC_WIDTH = SIG_RESUME + 1;
  // Modem status register fields.
  localparam int STAT_DELTA_CTS = 0;
  localparam int STAT_DELTA_DSR = 1;
  localparam int STAT_TRAIL_RI = 2;
  localparam int STAT_DELTA_DCD = 3;
  localparam int STAT_CTS = 4;
  localparam int STAT_DSR = 5;
  localparam int STAT_RI = 6;
  localparam int STAT_DCD = 7;
  // Modem control register fields.
  localparam int CTRL_RTS = 0;
  localparam int CTRL_DTR = 1;
  localparam int CTRL_LOOP = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Interrupt enable field for modem status changes.
  localparam int IER_MODEM = 3;
  // Idle levels of the synchroniser: handshake pins idle high, resume reset held.
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = {1'b0, {(SYNC_WIDTH-1){1'b1}}};
  localparam logic [MODEM_SIGS-1:0] SIG_IDLE = {MODEM_SIGS{1'b1}};
  typedef logic [7:0] umh_byte_t;
endpackage : umh_pkg

// [rtl/umh_sync3.sv]
`timescale 1ns/10ps
module umh_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // ==========================================================
  // Three-stage capture; a level is accepted once stages two and three agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
    end else if (ce) begin
      stage1_reg <= d;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          q[i] <= RESET_VAL[i];
        end else if (ce && (stage2_reg[i] == stage3_reg[i])) begin
          q[i] <= stage3_reg[i];
        end
      end
    end
  endgenerate
endmodule : umh_sync3

// [rtl/umh_top.sv]
`timescale 1ns/10ps
module umh_top (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic RESUME_RESET_N,
  input wire logic [umh_pkg::NUM_PORTS-1:0] CTS_N,
  input wire logic [umh_pkg::NUM_PORTS-1:0] DSR_N,
  input wire logic [umh_pkg::NUM_PORTS-1:0] RING_INDICATOR_N,
  input wire logic [umh_pkg::NUM_PORTS-1:0] DCD_N,
  input wire logic [umh_pkg::NUM_PORTS-1:0] RXD,
  input wire logic [umh_pkg::NUM_PORTS-1:0] TX_DATA_IN,
  input wire logic [umh_pkg::NUM_PORTS-1:0] MODEM_STATUS_READ,
  input wire logic [umh_pkg::NUM_PORTS-1:0] MODEM_CONTROL_WE,
  input wire logic [umh_pkg::NUM_PORTS-1:0][7:0] MODEM_CONTROL_WDATA,
  input wire logic [umh_pkg::NUM_PORTS-1:0][7:0] INT_ENABLE,
  input wire logic [umh_pkg::NUM_PORTS-1:0] DTR_ENABLE,
  input wire logic DTR_STRAP_IN,
  output logic [umh_pkg::NUM_PORTS-1:0][7:0] MODEM_STATUS_REG,
  output logic [umh_pkg::NUM_PORTS-1:0][7:0] MODEM_CONTROL_REG,
  output logic [umh_pkg::NUM_PORTS-1:0] PORT_IRQ,
  output logic [umh_pkg::NUM_PORTS-1:0] DTR_N_OUT,
  output logic [umh_pkg::NUM_PORTS-1:0] DTR_OE,
  output logic [umh_pkg::NUM_PORTS-1:0] RTS_N,
  output logic [umh_pkg::NUM_PORTS-1:0] TXD,
  output logic [umh_pkg::NUM_PORTS-1:0] RX_DATA,
  output logic TEST_ENABLE
);
  import umh_pkg::*;

  // ==========================================================
  // Helpers.
  // A pin going low to high is a handshake line being released.
  function automatic logic [MODEM_SIGS-1:0] rise_of(input logic [MODEM_SIGS-1:0] prev,
                                                     input logic [MODEM_SIGS-1:0] cur);
    rise_of = ~prev & cur;
  endfunction : rise_of

  function automatic logic [MODEM_SIGS-1:0] change_of(input logic [MODEM_SIGS-1:0] prev,
                                                       input logic [MODEM_SIGS-1:0] cur);
    change_of = prev ^ cur;
  endfunction : change_of

  // ==========================================================
  // Input synchronisation.
  logic [SYNC_WIDTH-1:0] pins_raw;
  logic [SYNC_WIDTH-1:0] pins_sync;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_pins
      assign pins_raw[p*SIGS_PER_PORT+SIG_CTS] = CTS_N[p];
      assign pins_raw[p*SIGS_PER_PORT+SIG_DSR] = DSR_N[p];
      assign pins_raw[p*SIGS_PER_PORT+SIG_RI] = RING_INDICATOR_N[p];
      assign pins_raw[p*SIGS_PER_PORT+SIG_DCD] = DCD_N[p];
      assign pins_raw[p*SIGS_PER_PORT+SIG_RXD] = RXD[p];
    end
  endgenerate
  assign pins_raw[SIG_DTR_STRAP] = DTR_STRAP_IN;
  assign pins_raw[SIG_RESUME] = RESUME_RESET_N;

  umh_sync3 #(
    .WIDTH(SYNC_WIDTH),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .clk(CLOCK),
    .rst_n(RST_N),
    .ce(CE),
    .d(pins_raw),
    .q(pins_sync)
  );

  // ==========================================================
  // Test-enable strap, caught from the terminal-ready pin while resume reset is held.
  logic test_enable_reg;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      test_enable_reg <= 1'b0;
    end else if (CE && !pins_sync[SIG_RESUME]) begin
      test_enable_reg <= pins_sync[SIG_DTR_STRAP];
    end
  end
  assign TEST_ENABLE = test_enable_reg;

  // ==========================================================
  // Per-port handshake logic; the second port is an exact copy of the first.
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [MODEM_SIGS-1:0] lvl_now;
      logic [MODEM_SIGS-1:0] lvl_prev_reg;
      logic [MODEM_SIGS-1:0] shown_reg;
      logic [MODEM_SIGS-1:0] rise;
      logic [MODEM_SIGS-1:0] change;
      logic [3:0] delta_reg;
      logic [3:0] delta_next;
      logic pending_reg;
      logic pending_next;
      logic irq_reg;
      umh_byte_t mcr_reg;
      logic dtr_n_reg;
      logic dtr_oe_reg;
      logic rts_n_reg;
      logic txd_reg;
      logic rxd_reg;

      assign lvl_now = pins_sync[p*SIGS_PER_PORT +: MODEM_SIGS];
      assign rise = rise_of(lvl_prev_reg, lvl_now);
      assign change = change_of(lvl_prev_reg, lvl_now);

      // Change flags: a new event in the read cycle survives the clear.
      always_comb begin
        delta_next = delta_reg & ~{4{MODEM_STATUS_READ[p]}};
        delta_next[STAT_DELTA_CTS] = delta_next[STAT_DELTA_CTS] | rise[SIG_CTS];
        delta_next[STAT_DELTA_DSR] = delta_next[STAT_DELTA_DSR] | rise[SIG_DSR];
        delta_next[STAT_TRAIL_RI] = delta_next[STAT_TRAIL_RI] | rise[SIG_RI];
        delta_next[STAT_DELTA_DCD] = delta_next[STAT_DELTA_DCD] | rise[SIG_DCD];
      end

      // Any state change of a modem line requests the port interrupt.
      always_comb begin
        pending_next = (pending_reg & ~MODEM_STATUS_READ[p]) | (|change);
      end

      // Line levels: the previous level feeds the edge detectors, the inverted copy feeds the status byte.
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          lvl_prev_reg <= SIG_IDLE;
          shown_reg <= ~SIG_IDLE;
        end else if (CE) begin
          lvl_prev_reg <= lvl_now;
          shown_reg <= ~lvl_now;
        end
      end

      // Change flags.
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          delta_reg <= '0;
        end else if (CE) begin
          delta_reg <= delta_next;
        end
      end

      // Pending modem interrupt, kept until the status is read.
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          pending_reg <= 1'b0;
        end else if (CE) begin
          pending_reg <= pending_next;
        end
      end

      // Interrupt output; the enable bit gates only the output.
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          irq_reg <= 1'b0;
        end else if (CE) begin
          irq_reg <= pending_next & INT_ENABLE[p][IER_MODEM];
        end
      end

      // Status register: levels shown as asserted-high copies of the low-active pins.
      always_comb begin
        MODEM_STATUS_REG[p] = '0;
        MODEM_STATUS_REG[p][STAT_DELTA_CTS +: MODEM_SIGS] = delta_reg;
        MODEM_STATUS_REG[p][STAT_CTS] = shown_reg[SIG_CTS];
        MODEM_STATUS_REG[p][STAT_DSR] = shown_reg[SIG_DSR];
        MODEM_STATUS_REG[p][STAT_RI] = shown_reg[SIG_RI];
        MODEM_STATUS_REG[p][STAT_DCD] = shown_reg[SIG_DCD];
      end
      assign PORT_IRQ[p] = irq_reg;

      // Modem control register.
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          mcr_reg <= CTRL_RESET;
        end else if (CE && MODEM_CONTROL_WE[p]) begin
          mcr_reg <= MODEM_CONTROL_WDATA[p];
        end
      end
      assign MODEM_CONTROL_REG[p] = mcr_reg;

      // Handshake outputs; terminal-ready stays undriven until enabled.
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          dtr_n_reg <= 1'b1;
          dtr_oe_reg <= 1'b0;
        end else if (CE) begin
          dtr_n_reg <= ~mcr_reg[CTRL_DTR];
          dtr_oe_reg <= DTR_ENABLE[p];
        end
      end

      // Request-to-send is held inactive while loop mode is on.
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          rts_n_reg <= 1'b1;
        end else if (CE) begin
          rts_n_reg <= ~mcr_reg[CTRL_RTS] | mcr_reg[CTRL_LOOP];
        end
      end
      assign DTR_N_OUT[p] = dtr_n_reg;
      assign DTR_OE[p] = dtr_oe_reg;
      assign RTS_N[p] = rts_n_reg;

      // Serial data: transmit is never gated by clear-to-send.
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          txd_reg <= 1'b1;
        end else if (CE) begin
          txd_reg <= TX_DATA_IN[p];
        end
      end

      // Receive data leaves the synchroniser with one more register stage.
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          rxd_reg <= 1'b1;
        end else if (CE) begin
          rxd_reg <= pins_sync[p*SIGS_PER_PORT+SIG_RXD];
        end
      end
      assign TXD[p] = txd_reg;
      assign RX_DATA[p] = rxd_reg;
    end
  endgenerate
endmodule : umh_top

// [verification/umh_modem.sv]
`timescale 1ns/10ps
module umh_modem (
  input wire logic [1:0][4:0] want,
  output logic [1:0] cts_n,
  output logic [1:0] dsr_n,
  output logic [1:0] ri_n,
  output logic [1:0] dcd_n,
  output logic [1:0] rxd
);
  // ==========
  // Modem lines
  // The modem lowers CTS_N while it can take data; every line but RXD is asserted low.
  assign cts_n = ~{want[1][0], want[0][0]};
  assign dsr_n = ~{want[1][1], want[0][1]};
  assign ri_n = ~{want[1][2], want[0][2]};
  assign dcd_n = ~{want[1][3], want[0][3]};
  assign rxd = {want[1][4], want[0][4]};
endmodule : umh_modem

// [verification/umh_asserts.sv]
`timescale 1ns/10ps
module umh_asserts import umh_pkg::*; (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic RESUME_RESET_N,
  input wire logic [1:0] CTS_N,
  input wire logic [1:0] DSR_N,
  input wire logic [1:0] RING_INDICATOR_N,
  input wire logic [1:0] DCD_N,
  input wire logic [1:0] TX_DATA_IN,
  input wire logic [1:0] MODEM_STATUS_READ,
  input wire logic [1:0] MODEM_CONTROL_WE,
  input wire logic [1:0][7:0] MODEM_CONTROL_WDATA,
  input wire logic [1:0][7:0] INT_ENABLE,
  input wire logic [1:0] DTR_ENABLE,
  input wire logic DTR_STRAP_IN,
  input wire logic [1:0][7:0] MODEM_STATUS_REG,
  input wire logic [1:0][7:0] MODEM_CONTROL_REG,
  input wire logic [1:0] PORT_IRQ,
  input wire logic [1:0] DTR_N_OUT,
  input wire logic [1:0] DTR_OE,
  input wire logic [1:0] RTS_N,
  input wire logic [1:0] TXD,
  input wire logic TEST_ENABLE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N || !CE);
  logic [3:0] quiet_reg;
  // ==========
  // Counts cycles since a port 0 modem line last moved, so reads see a drained pipeline.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) quiet_reg <= 4'h0;
    else if (!$stable({CTS_N[0], DSR_N[0], RING_INDICATOR_N[0], DCD_N[0]})) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
  end
  a_cts_level: assert property ($fell(CTS_N[0]) ##1 (!CTS_N[0]) [*6] |-> MODEM_STATUS_REG[0][STAT_CTS])
    else $error("cts level missing");
  a_cts_delta: assert property ($rose(CTS_N[0]) ##1 (CTS_N[0] && !MODEM_STATUS_READ[0]) [*7]
    |-> MODEM_STATUS_REG[0][STAT_DELTA_CTS]) else $error("cts delta missing");
  a_dcd_delta: assert property ($rose(DCD_N[1]) ##1 (DCD_N[1] && !MODEM_STATUS_READ[1]) [*7]
    |-> MODEM_STATUS_REG[1][STAT_DELTA_DCD]) else $error("dcd delta missing");
  a_line_irq: assert property ($changed({CTS_N[0], RING_INDICATOR_N[0]}) ##1 (INT_ENABLE[0][IER_MODEM]
    && !MODEM_STATUS_READ[0]) [*7] |-> PORT_IRQ[0]) else $error("irq missing");
  a_read_clear: assert property (MODEM_STATUS_READ[0] && quiet_reg > 4'h8
    |=> MODEM_STATUS_REG[0][3:0] == 4'h0 && !PORT_IRQ[0]) else $error("read did not clear");
  a_dtr_follow: assert property (MODEM_CONTROL_WE[0] ##1 !MODEM_CONTROL_WE[0]
    |=> DTR_N_OUT[0] != $past(MODEM_CONTROL_WDATA[0][CTRL_DTR], 2)) else $error("dtr wrong");
  a_dtr_float: assert property (1 |=> DTR_OE == $past(DTR_ENABLE)) else $error("dtr enable wrong");
  a_rts_loop: assert property (MODEM_CONTROL_REG[0][CTRL_LOOP] |=> RTS_N[0]) else $error("rts active");
  a_tx_free: assert property (CE |=> TXD == $past(TX_DATA_IN)) else $error("txd gated");
  a_strap_track: assert property ((!RESUME_RESET_N && $stable(DTR_STRAP_IN)) [*8]
    |-> TEST_ENABLE == DTR_STRAP_IN) else $error("strap not sampled");
  c_read: cover property (MODEM_STATUS_READ[0] && PORT_IRQ[0]);
  c_loop: cover property (MODEM_CONTROL_REG[0][CTRL_LOOP]);
  c_strap: cover property (TEST_ENABLE && RESUME_RESET_N);
endmodule : umh_asserts
bind umh_top umh_asserts u_asserts (.*);

// [verification/umh_top_tb.sv]
`timescale 1ns/10ps
module umh_top_tb;
  import umh_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, ce = 1'b1, resume_n = 1'b0, strap = 1'b1, look = 1'b0;
  logic [1:0] tx_in = '0, rd = '0, we = '0, dtr_en = '0, pend = '0;
  logic [1:0][7:0] wdata = '0, ie = '0, status, ctrl;
  logic [1:0][4:0] want = '0;
  logic [1:0][3:0] lv = '0, dl = '0;
  logic [1:0] cts_n, dsr_n, ri_n, dcd_n, rxd, irq, dtr_n, dtr_oe, rts_n, txd, rx_data;
  logic test_en;
  logic [10:0] e;
  logic [10:0] q [$];
  logic [7:0] cw [4] = '{8'h07, 8'h11, 8'h17, 8'h00};
  int seed = 55, n_mismatch = 0, compares = 0;
  always #12.5 clock = ~clock;
  umh_top dut (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .RESUME_RESET_N(resume_n), .CTS_N(cts_n),
    .DSR_N(dsr_n), .RING_INDICATOR_N(ri_n), .DCD_N(dcd_n), .RXD(rxd), .TX_DATA_IN(tx_in),
    .MODEM_STATUS_READ(rd), .MODEM_CONTROL_WE(we), .MODEM_CONTROL_WDATA(wdata), .INT_ENABLE(ie),
    .DTR_ENABLE(dtr_en), .DTR_STRAP_IN(strap), .MODEM_STATUS_REG(status), .MODEM_CONTROL_REG(ctrl),
    .PORT_IRQ(irq), .DTR_N_OUT(dtr_n), .DTR_OE(dtr_oe), .RTS_N(rts_n), .TXD(txd), .RX_DATA(rx_data),
    .TEST_ENABLE(test_en));
  umh_modem modem (.want(want), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .rxd(rxd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic note(input logic [10:0] v);
    @(posedge clock);
    q.push_back(v);
    look <= 1'b1;
    @(posedge clock);
    look <= 1'b0;
  endtask : note
  // ==========
  // Random line changes on one port, with the expected status worked out from the previous levels.
  task automatic step(input int p);
    logic [4:0] w;
    logic en;
    w = 5'($random(seed));
    en = 1'($random(seed));
    @(posedge clock);
    want[p] <= w;
    ie[p][IER_MODEM] <= en;
    tx_in <= 2'($random(seed));
    dl[p] = dl[p] | (lv[p] & ~w[3:0]);
    pend[p] = pend[p] | (lv[p] != w[3:0]);
    lv[p] = w[3:0];
    repeat (8) @(posedge clock);
    note({w[4], pend[p] & en, p[0], w[3:0], dl[p]});
  endtask : step
  task automatic rdst(input int p);
    @(posedge clock);
    rd[p] <= 1'b1;
    @(posedge clock);
    rd[p] <= 1'b0;
    dl[p] = 4'h0;
    pend[p] = 1'b0;
    @(posedge clock);
    note({want[p][4], 1'b0, p[0], lv[p], 4'h0});
  endtask : rdst
  always @(negedge clock) begin
    if (look) begin
      e = q.pop_front();
      chk({7'h00, irq[e[8]]}, {7'h00, e[9]}, "irq");
      chk(status[e[8]], e[7:0], "status");
      chk({7'h00, rx_data[e[8]]}, {7'h00, e[10]}, "rxd");
    end
  end
  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(negedge clock);
    chk({7'h00, test_en}, 8'h01, "strap");
    chk({6'h00, dtr_oe}, 8'h00, "dtr float");
    chk({6'h00, rts_n}, 8'h03, "rts reset");
    @(posedge clock);
    resume_n <= 1'b1;
    repeat (8) @(posedge clock);
    strap <= 1'b0;
    repeat (8) @(negedge clock);
    chk({7'h00, test_en}, 8'h01, "strap frozen");
    @(posedge clock);
    note(11'h000);
    note(11'h100);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      step(i % 2);
      if (i % 3 == 2) rdst(i % 2);
    end
    $display("status test done");
    foreach (cw[i]) begin
      @(posedge clock);
      we[0] <= 1'b1;
      wdata[0] <= cw[i];
      dtr_en <= {2{cw[i][2]}};
      @(posedge clock);
      we[0] <= 1'b0;
      repeat (2) @(negedge clock);
      chk(ctrl[0], cw[i], "ctrl readback");
      chk({7'h00, dtr_n[0]}, {7'h00, ~cw[i][1]}, "dtr level");
      chk({7'h00, rts_n[0]}, {7'h00, ~(cw[i][0] & ~cw[i][4])}, "rts level");
      chk({7'h00, dtr_oe[0]}, {7'h00, cw[i][2]}, "dtr drive");
    end
    $display("control test done");
    results();
  end
endmodule : umh_top_tb
